// file: debug_port_defs.svh
// Offsets, field positions, codes and reset values of the debug port registers
`ifndef DEBUG_PORT_DEFS_SVH
`define DEBUG_PORT_DEFS_SVH
// ==========================================================
// Register offsets
`define REG_REVISION 4'h0
`define REG_ERROR 4'h1
`define REG_CTRL_PRI 4'h2
`define REG_CTRL_SEC 4'h3
`define REG_KEYS 4'h7
`define REG_RESET_REQ 4'h8
`define REG_CLK_SEL 4'h9
// ==========================================================
// Field positions
`define CA_GAP 7
`define CA_PARITY_OFF 5
`define CA_TIMEOUT_OFF 4
`define CA_RESP_OFF 3
`define CB_NACK_OFF 4
`define CB_CONT_OFF 3
`define CB_DISABLE 2
`define KEY_USER_ROW 5
`define KEY_PROGRAM 4
`define KEY_ERASE 3
`define CTRL_PRI_MASK 8'hBF
`define CTRL_SEC_MASK 8'h18
// ==========================================================
// Error signatures
`define ERR_NONE 3'h0
`define ERR_PARITY 3'h1
`define ERR_FRAME 3'h2
`define ERR_TIMEOUT 3'h3
`define ERR_START 3'h4
`define ERR_BUS 3'h6
`define ERR_CONTENTION 3'h7
// ==========================================================
// Codes, reset values and timing
`define RESET_CODE 8'h59
`define RUN_CODE 8'h00
`define CLKDIV_RESET 2'h3
`define GT_RESERVED 3'h7
`define GUARD_MAX 8'h80
`define GAP_BITS 8'h02
`define TIMEOUT_WIDTH 17
`endif

// file: debug_port_pkg.sv
// Types shared by the debug port control logic
package debug_port_pkg;
  // Link turnaround and gap sequencer states
  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_GUARD = 3'b010,
    LS_GAP = 3'b100
  } link_state_type;
endpackage : debug_port_pkg

// file: link_timer_if.sv
// Signals between the register block and its link timer
`timescale 1ns/10ps
interface link_timer_if;
  logic [7:0] guard_cycles;
  logic gap_enable;
  logic timeout_off;
  logic turnaround;
  logic byte_done;
  logic bit_tick;
  logic acc_wait;
  logic acc_resp;
  logic tx_ready;
  logic timeout_event;
  modport ctrl (output guard_cycles, gap_enable, timeout_off, turnaround, byte_done,
    bit_tick, acc_wait, acc_resp, input tx_ready, timeout_event);
  modport timer (input guard_cycles, gap_enable, timeout_off, turnaround, byte_done,
    bit_tick, acc_wait, acc_resp, output tx_ready, timeout_event);
endinterface : link_timer_if

// file: link_timer.sv
// Guard time, inter-byte gap and access time-out timing
`timescale 1ns/10ps
`include "debug_port_defs.svh"
module link_timer #(
  parameter int TIMEOUT_CYCLES = 65536
) (
  input wire logic sys_clk,
  input wire logic reset,
  link_timer_if.timer t
);
  localparam logic [`TIMEOUT_WIDTH-1:0] WAIT_LIMIT = `TIMEOUT_WIDTH'(TIMEOUT_CYCLES - 1);
  debug_port_pkg::link_state_type state;
  debug_port_pkg::link_state_type next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [`TIMEOUT_WIDTH-1:0] wait_cnt;
  logic [`TIMEOUT_WIDTH-1:0] next_wait_cnt;
  logic timeout;
  logic next_timeout;

  // ==========================================================
  // Next state of sequencer and time-out counter
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      debug_port_pkg::LS_IDLE:
      begin
        if (t.turnaround)
        begin
          next_state = debug_port_pkg::LS_GUARD;
          next_cnt = t.guard_cycles - 8'h01;
        end
        else if (t.byte_done && t.gap_enable)
        begin
          next_state = debug_port_pkg::LS_GAP;
          next_cnt = `GAP_BITS;
        end
      end
      debug_port_pkg::LS_GUARD:
      begin
        if (cnt == 8'h00)
          next_state = debug_port_pkg::LS_IDLE;
        else
          next_cnt = cnt - 8'h01;
      end
      debug_port_pkg::LS_GAP:
      begin
        if (t.bit_tick)
        begin
          if (cnt == 8'h01)
            next_state = debug_port_pkg::LS_IDLE;
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = debug_port_pkg::LS_IDLE;
    endcase
    // Access wait counter, restarted by any answer
    next_timeout = 1'b0;
    if (!t.acc_wait || t.acc_resp || t.timeout_off)
      next_wait_cnt = '0;
    else if (wait_cnt == WAIT_LIMIT)
    begin
      next_wait_cnt = '0;
      next_timeout = 1'b1;
    end
    else
      next_wait_cnt = wait_cnt + `TIMEOUT_WIDTH'(1);
  end

  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state <= debug_port_pkg::LS_IDLE;
      cnt <= 8'h00;
      wait_cnt <= '0;
      timeout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wait_cnt <= next_wait_cnt;
      timeout <= next_timeout;
    end
  end

  assign t.tx_ready = (state == debug_port_pkg::LS_IDLE);
  assign t.timeout_event = timeout;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Two busy cycles, then the link may transmit again
  sequence guard_two_s;
    !t.tx_ready ##1 !t.tx_ready ##1 t.tx_ready;
  endsequence
  guard_length_a: assert property ((t.tx_ready && t.turnaround
    && t.guard_cycles == 8'h02) |=> guard_two_s) else $error("guard time wrong");
  gap_start_a: assert property ((t.tx_ready && !t.turnaround && t.byte_done
    && t.gap_enable) |=> !t.tx_ready) else $error("no inter-byte gap");
  timeout_off_a: assert property (t.timeout_off |=> !t.timeout_event)
    else $error("time-out while disabled");
endmodule : link_timer

// file: debug_port_control_regs.sv
// Debugger-only control and status registers of the single-wire debug port
//
// What this block does
// - Registers reachable only through debugger port.
// - Read-only revision nibble in first status.
// - Error signature loaded on error, read clears.
// - Fixed codes per error kind, code 5 reserved.
// - Optional two bit-time gap between bytes.
// - Parity-off bit ignores received parity.
// - Access time-out after count, can disable.
// - Response-off bit suppresses response signatures.
// - Three-bit guard time before receive-to-transmit.
// - NACK on reset during load/store unless off.
// - Contention detection unless its off bit set.
// - Disable bit resets link, config and keys.
// - User-row key flag, written to end session.
// - Program key flag cleared at programming start.
// - Erase key flag cleared by erase reset.
// - Code 0x59 holds system reset, 0x00 releases.
// - System reset leaves this logic untouched.
// - Link clock divider, back to 3 on enable.
// - System clock requested while interface enabled.
`timescale 1ns/10ps
`include "debug_port_defs.svh"
module debug_port_control_regs #(
  parameter int TIMEOUT_CYCLES = 65536,
  parameter logic [3:0] REVISION = 4'h2 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic interface_enable,
  input wire logic parity_fail,
  input wire logic frame_fail,
  input wire logic start_fail,
  input wire logic bus_fail,
  input wire logic contention_seen,
  input wire logic turnaround_req,
  input wire logic tx_byte_done,
  input wire logic bit_tick,
  input wire logic acc_wait,
  input wire logic acc_resp,
  input wire logic resp_req,
  input wire logic load_store_busy,
  input wire logic user_row_write_key,
  input wire logic memory_program_key,
  input wire logic chip_erase_key,
  input wire logic programming_start_flag,
  output logic tx_ready,
  output logic resp_send,
  output logic reset_nack,
  output logic user_row_session_end,
  output logic system_reset_out,
  output logic [1:0] link_clock_divider,
  output logic system_clock_request,
  output logic interface_enabled
);
  logic [7:0] ctrl_pri;
  logic [7:0] next_ctrl_pri;
  logic [7:0] ctrl_sec;
  logic [7:0] next_ctrl_sec;
  logic [2:0] keys;
  logic [2:0] next_keys;
  logic [7:0] reset_req;
  logic [7:0] next_reset_req;
  logic [1:0] clk_div;
  logic [1:0] next_clk_div;
  logic [2:0] error_signature;
  logic [2:0] next_error_signature;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic sys_rst;
  logic next_sys_rst;
  logic nack;
  logic next_nack;
  logic urow_end;
  logic next_urow_end;
  logic enabled;
  logic next_enabled;
  logic prog_start_d;
  logic err_hit;
  logic [2:0] err_code;
  logic wr;
  logic rd;
  logic [7:0] key_bits;
  link_timer_if tif();

  // ==========================================================
  // Access qualification: only the debugger port exists
  assign wr = reg_write && enabled;
  assign rd = reg_read && enabled;
  assign key_bits = {2'b00, keys, 3'b000};

  // ==========================================================
  // Link timer hookup
  assign tif.guard_cycles = (ctrl_pri[2:0] == `GT_RESERVED) ? `GUARD_MAX
    : (`GUARD_MAX >> ctrl_pri[2:0]);
  assign tif.gap_enable = ctrl_pri[`CA_GAP];
  assign tif.timeout_off = ctrl_pri[`CA_TIMEOUT_OFF];
  assign tif.turnaround = turnaround_req;
  assign tif.byte_done = tx_byte_done;
  assign tif.bit_tick = bit_tick;
  assign tif.acc_wait = acc_wait;
  assign tif.acc_resp = acc_resp;

  link_timer #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .t(tif.timer)
  );

  // ==========================================================
  // Error source selection, most severe wins within one cycle
  always_comb
  begin
    err_hit = 1'b1;
    err_code = `ERR_NONE;
    if (contention_seen && !ctrl_sec[`CB_CONT_OFF])
      err_code = `ERR_CONTENTION;
    else if (bus_fail)
      err_code = `ERR_BUS;
    else if (tif.timeout_event)
      err_code = `ERR_TIMEOUT;
    else if (start_fail)
      err_code = `ERR_START;
    else if (frame_fail)
      err_code = `ERR_FRAME;
    else if (parity_fail && !ctrl_pri[`CA_PARITY_OFF])
      err_code = `ERR_PARITY;
    else
      err_hit = 1'b0;
  end

  // ==========================================================
  // Next register values
  always_comb
  begin
    next_ctrl_pri = ctrl_pri;
    next_ctrl_sec = ctrl_sec;
    next_keys = keys;
    next_reset_req = reset_req;
    next_clk_div = clk_div;
    next_error_signature = error_signature;
    next_rdata = rdata;
    next_sys_rst = sys_rst;
    next_nack = 1'b0;
    next_urow_end = 1'b0;
    next_enabled = enabled;
    // Read mux, data held until next read
    if (rd)
    begin
      case (reg_addr)
        `REG_REVISION: next_rdata = {REVISION, 4'h0};
        `REG_ERROR: next_rdata = {5'b00000, error_signature};
        `REG_CTRL_PRI: next_rdata = ctrl_pri;
        `REG_CTRL_SEC: next_rdata = ctrl_sec;
        `REG_KEYS: next_rdata = key_bits;
        `REG_RESET_REQ: next_rdata = reset_req;
        `REG_CLK_SEL: next_rdata = {6'b000000, clk_div};
        default: next_rdata = 8'h00;
      endcase
    end
    // Error signature: new error wins over read clear
    if (err_hit && enabled)
      next_error_signature = err_code;
    else if (rd && reg_addr == `REG_ERROR)
      next_error_signature = `ERR_NONE;
    // User row key: a write of one closes the session
    if (wr && reg_addr == `REG_KEYS && reg_wdata[`KEY_USER_ROW])
    begin
      next_keys[2] = 1'b0;
      next_urow_end = 1'b1;
    end
    // Program key cleared when programming starts
    if (programming_start_flag && !prog_start_d)
      next_keys[1] = 1'b0;
    // System reset request, other codes are stored but leave the system reset unchanged
    if (wr && reg_addr == `REG_RESET_REQ)
    begin
      next_reset_req = reg_wdata;
      if (reg_wdata == `RESET_CODE)
      begin
        next_sys_rst = 1'b1;
        next_keys[0] = 1'b0;
        next_nack = !sys_rst && load_store_busy && !ctrl_sec[`CB_NACK_OFF];
      end
      else if (reg_wdata == `RUN_CODE)
        next_sys_rst = 1'b0;
    end
    // Key decodes set their flags, winning over all clears but the disable write
    if (user_row_write_key && enabled)
      next_keys[2] = 1'b1;
    if (memory_program_key && enabled)
      next_keys[1] = 1'b1;
    if (chip_erase_key && enabled)
      next_keys[0] = 1'b1;
    // Configuration writes
    if (wr && reg_addr == `REG_CTRL_PRI)
      next_ctrl_pri = reg_wdata & `CTRL_PRI_MASK;
    if (wr && reg_addr == `REG_CLK_SEL)
      next_clk_div = reg_wdata[1:0];
    if (wr && reg_addr == `REG_CTRL_SEC)
    begin
      next_ctrl_sec = reg_wdata & `CTRL_SEC_MASK;
      if (reg_wdata[`CB_DISABLE])
      begin
        next_enabled = 1'b0;
        next_ctrl_pri = 8'h00;
        next_ctrl_sec = 8'h00;
        next_keys = 3'b000;
        next_clk_div = `CLKDIV_RESET;
        next_error_signature = `ERR_NONE;
      end
    end
    // Re-enable restores the default divider
    if (interface_enable && !enabled)
    begin
      next_enabled = 1'b1;
      next_clk_div = `CLKDIV_RESET;
    end
  end

  // Registers; system reset output does not feed back here
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_pri <= 8'h00;
      ctrl_sec <= 8'h00;
      keys <= 3'b000;
      reset_req <= 8'h00;
      clk_div <= `CLKDIV_RESET;
      error_signature <= `ERR_NONE;
      rdata <= 8'h00;
      sys_rst <= 1'b0;
      nack <= 1'b0;
      urow_end <= 1'b0;
      enabled <= 1'b1;
      prog_start_d <= 1'b0;
    end
    else
    begin
      ctrl_pri <= next_ctrl_pri;
      ctrl_sec <= next_ctrl_sec;
      keys <= next_keys;
      reset_req <= next_reset_req;
      clk_div <= next_clk_div;
      error_signature <= next_error_signature;
      rdata <= next_rdata;
      sys_rst <= next_sys_rst;
      nack <= next_nack;
      urow_end <= next_urow_end;
      enabled <= next_enabled;
      prog_start_d <= programming_start_flag;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = rdata;
  assign tx_ready = tif.tx_ready;
  assign resp_send = resp_req && enabled && !ctrl_pri[`CA_RESP_OFF];
  assign reset_nack = nack;
  assign user_row_session_end = urow_end;
  assign system_reset_out = sys_rst;
  assign link_clock_divider = clk_div;
  assign system_clock_request = enabled;
  assign interface_enabled = enabled;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Accepted writes that start a behaviour, and cycles with no reset request write
  sequence reset_write_s;
    wr && reg_addr == `REG_RESET_REQ && reg_wdata == `RESET_CODE;
  endsequence
  sequence run_write_s;
    wr && reg_addr == `REG_RESET_REQ && reg_wdata == `RUN_CODE;
  endsequence
  sequence quiet_s;
    !(wr && reg_addr == `REG_RESET_REQ);
  endsequence
  sequence disable_write_s;
    wr && reg_addr == `REG_CTRL_SEC && reg_wdata[`CB_DISABLE];
  endsequence
  sequence urow_close_s;
    wr && reg_addr == `REG_KEYS && reg_wdata[`KEY_USER_ROW];
  endsequence
  sequence resp_off_write_s;
    wr && reg_addr == `REG_CTRL_PRI && reg_wdata[`CA_RESP_OFF];
  endsequence
  // Register port: refused writes and held read data
  rdata_hold_a: assert property (!rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  refuse_write_a: assert property ((reg_write && !enabled)
    |=> $stable(ctrl_pri) && $stable(ctrl_sec)) else $error("write taken while disabled");
  revision_read_a: assert property ((rd && reg_addr == `REG_REVISION)
    |=> reg_rdata == {REVISION, 4'h0}) else $error("revision field wrong");
  // Reset request holds and releases the system reset
  reset_hold_a: assert property (reset_write_s ##1 quiet_s |=> system_reset_out)
    else $error("system reset not held");
  reset_release_a: assert property (run_write_s |=> !system_reset_out)
    else $error("system reset not released");
  // Error signature capture, read clear and gating
  sig_clear_a: assert property ((rd && reg_addr == `REG_ERROR && !err_hit)
    |=> error_signature == `ERR_NONE) else $error("signature not cleared");
  sig_load_a: assert property ((enabled && bus_fail && !contention_seen
    && !(wr && reg_addr == `REG_CTRL_SEC && reg_wdata[`CB_DISABLE]))
    |=> error_signature == `ERR_BUS) else $error("bus error not recorded");
  parity_gate_a: assert property ((ctrl_pri[`CA_PARITY_OFF]
    && error_signature != `ERR_PARITY && !(rd && reg_addr == `REG_ERROR))
    ##1 !bus_fail && !frame_fail |-> error_signature != `ERR_PARITY)
    else $error("parity reported while off");
  cont_gate_a: assert property ((ctrl_sec[`CB_CONT_OFF]
    && error_signature != `ERR_CONTENTION) |=> error_signature != `ERR_CONTENTION)
    else $error("contention reported while off");
  // Response and NACK gating
  resp_gate_a: assert property (resp_off_write_s |=> !resp_send)
    else $error("response sent while off");
  nack_send_a: assert property ((reset_write_s and (!sys_rst && load_store_busy
    && !ctrl_sec[`CB_NACK_OFF])) |=> reset_nack ##1 !reset_nack)
    else $error("nack missing");
  nack_quiet_a: assert property (ctrl_sec[`CB_NACK_OFF] |=> !reset_nack)
    else $error("nack sent while off");
  // Disable, enable and key flags
  disable_all_a: assert property (disable_write_s |=> !interface_enabled
    && !system_clock_request && ctrl_pri == 8'h00 && keys == 3'b000)
    else $error("disable did not reset");
  enable_div_a: assert property ((interface_enable && !enabled)
    |=> link_clock_divider == `CLKDIV_RESET) else $error("divider not restored");
  session_end_a: assert property (urow_close_s |=> user_row_session_end)
    else $error("session end missing");
  prog_set_a: assert property ((enabled && memory_program_key
    && !(wr && reg_addr == `REG_CTRL_SEC && reg_wdata[`CB_DISABLE])) |=> keys[1])
    else $error("program key not set");
  prog_key_a: assert property (($rose(programming_start_flag) && !memory_program_key)
    |=> !keys[1]) else $error("program key not cleared");
  erase_key_a: assert property ((reset_write_s and !chip_erase_key) |=> !keys[0])
    else $error("erase key not cleared");
endmodule : debug_port_control_regs

// file: debugger_model.sv
// Debugger side of the register port: single-cycle reads and writes
`timescale 1ns/10ps
module debugger_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  // ====
  // Idle bus at time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // One write, held from a falling edge over the taking rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge sys_clk);
    reg_write = 1'b0;
    reg_wdata = ~d; // Stale byte is never left on the bus
  endtask : wr
  // One read, data taken one cycle after the request
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge sys_clk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : debugger_model

// file: debug_port_control_regs_tb.sv
// Self-checking bench of the debug port control registers
`timescale 1ns/10ps
module debug_port_control_regs_tb;
  // ====
  // Signals, counters and reference model
  localparam int TO = 16;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_write, reg_read;
  logic [4:0] ev = 5'h00; // Parity, frame, start, bus, contention
  logic [2:0] key = 3'h0; // Erase, program, user row
  logic en_p = 1'b0, turn = 1'b0, byte_done = 1'b0, tick = 1'b0, acc_wait = 1'b0;
  logic acc_resp = 1'b0, resp_req = 1'b0, ls_busy = 1'b0, prog_start = 1'b0;
  logic tx_ready, resp_send, reset_nack, session_end, sys_rst, clk_req, enabled;
  logic [1:0] div;
  logic [7:0] mdl [0:15];
  logic [2:0] codes [0:4] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  logic [31:0] seed = 32'h00000E0C;
  logic [31:0] r;
  int error_cnt = 0, samples_checked = 0, cycles = 0, cnt;

  debugger_model dbg (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

  debug_port_control_regs #(.TIMEOUT_CYCLES(TO), .REVISION(REV)) dut (.sys_clk(sys_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .interface_enable(en_p),
    .parity_fail(ev[0]), .frame_fail(ev[1]), .start_fail(ev[2]), .bus_fail(ev[3]),
    .contention_seen(ev[4]), .turnaround_req(turn), .tx_byte_done(byte_done),
    .bit_tick(tick), .acc_wait(acc_wait), .acc_resp(acc_resp), .resp_req(resp_req),
    .load_store_busy(ls_busy), .user_row_write_key(key[2]), .memory_program_key(key[1]),
    .chip_erase_key(key[0]), .programming_start_flag(prog_start), .tx_ready(tx_ready),
    .resp_send(resp_send), .reset_nack(reset_nack), .user_row_session_end(session_end),
    .system_reset_out(sys_rst), .link_clock_divider(div), .system_clock_request(clk_req),
    .interface_enabled(enabled));

  // Clock and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ====
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask : chk1
  // Write through the debugger and mirror the effect in the model
  task automatic mw(input logic [3:0] a, input logic [7:0] d);
    dbg.wr(a, d);
    case (a)
      4'h2: mdl[2] = d & 8'hBF;
      4'h3: mdl[3] = d & 8'h18;
      4'h7: if (d[5]) mdl[7][5] = 1'b0;
      4'h8: mdl[8] = d;
      4'h9: mdl[9] = {6'h00, d[1:0]};
      default: ;
    endcase
    if (a == 4'h8 && d == 8'h59) mdl[7][3] = 1'b0;
    if (a == 4'h3 && d[2])
    begin
      mdl[1] = 8'h00;
      mdl[2] = 8'h00;
      mdl[3] = 8'h00;
      mdl[7] = 8'h00;
      mdl[9] = 8'h03;
    end
  endtask : mw
  task automatic mr(input logic [3:0] a);
    logic [7:0] v;
    dbg.rd(a, v);
    check(v, mdl[a]);
    if (a == 4'h1) mdl[1] = 8'h00;
  endtask : mr
  task automatic err(input int i);
    @(negedge sys_clk) ev[i] = 1'b1;
    @(negedge sys_clk) ev[i] = 1'b0;
    if (!(i == 0 && mdl[2][5]) && !(i == 4 && mdl[3][3])) mdl[1] = {5'h00, codes[i]};
  endtask : err
  task automatic kp(input logic [2:0] k);
    @(negedge sys_clk) key = k;
    @(negedge sys_clk) key = 3'h0;
    mdl[7] = mdl[7] | {2'b00, k, 3'b000};
  endtask : kp
  task automatic hold_wait(input int n);
    acc_wait = 1'b1;
    repeat (n) @(negedge sys_clk);
    acc_wait = 1'b0;
  endtask : hold_wait
  task automatic end_of_test();
    $display("checked=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ====
  // Main sequence
  initial
  begin
    for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
    mdl[0] = {REV, 4'h0};
    mdl[9] = 8'h03;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    // Reset values, unmapped places and read-only places
    for (int a = 0; a < 10; a++) mr(a[3:0]);
    chk1(clk_req, 1'b1);
    mw(4'h0, 8'hFF);
    mr(4'h0);
    repeat (4)
    begin
      r = xs();
      mw(4'h2, r[7:0]);
      mr(4'h2);
      mw(4'h9, r[15:8]);
      check({6'h00, div}, mdl[9]);
    end
    mw(4'h2, 8'h00);
    // Every error code but the time-out, read clear, overwrite and the two off bits
    for (int i = 0; i < 5; i++)
    begin
      err(i);
      mr(4'h1);
      mr(4'h1);
    end
    err(0);
    err(3);
    mr(4'h1);
    mw(4'h2, 8'h20);
    err(0);
    mr(4'h1);
    mw(4'h3, 8'h08);
    err(4);
    mr(4'h1);
    mw(4'h3, 8'h00);
    err(4);
    mr(4'h1);
    // Access time-out, answered wait, disabled detection
    acc_wait = 1'b1;
    repeat (TO - 4) @(negedge sys_clk);
    acc_resp = 1'b1;
    @(negedge sys_clk) acc_resp = 1'b0;
    repeat (TO - 4) @(negedge sys_clk);
    acc_wait = 1'b0;
    mr(4'h1);
    hold_wait(TO + 2);
    mdl[1] = 8'h03;
    mr(4'h1);
    mw(4'h2, 8'h10);
    hold_wait(TO + 2);
    mr(4'h1);
    resp_req = 1'b1;
    #1 chk1(resp_send, 1'b1);
    mw(4'h2, 8'h08);
    #1 chk1(resp_send, 1'b0);
    resp_req = 1'b0;
    // Guard time of every code, then the inter-byte gap
    for (int s = 0; s < 8; s++)
    begin
      mw(4'h2, s[7:0]);
      @(negedge sys_clk) turn = 1'b1;
      @(negedge sys_clk) turn = 1'b0;
      cnt = 0;
      while (tx_ready === 1'b0 && cnt < 300)
      begin
        cnt++;
        @(negedge sys_clk);
      end
      check(cnt[7:0], (s == 7) ? 8'h80 : 8'h80 >> s);
    end
    for (int g = 0; g < 2; g++)
    begin
      mw(4'h2, {~g[0], 7'h00});
      @(negedge sys_clk) byte_done = 1'b1;
      @(negedge sys_clk) byte_done = 1'b0;
      chk1(tx_ready, g[0]);
      repeat (2) @(negedge sys_clk) tick = ~tick;
      chk1(tx_ready, g[0]);
      @(negedge sys_clk) tick = 1'b1;
      @(negedge sys_clk) tick = 1'b0;
      @(negedge sys_clk);
      chk1(tx_ready, 1'b1);
    end
    // Keys, reset request, NACK and session end
    mw(4'h2, 8'h44);
    kp(3'h7);
    mr(4'h7);
    prog_start = 1'b1;
    repeat (2) @(negedge sys_clk);
    mdl[7][4] = 1'b0;
    mr(4'h7);
    ls_busy = 1'b1;
    mw(4'h8, 8'h59);
    chk1(reset_nack, 1'b1);
    chk1(sys_rst, 1'b1);
    mr(4'h7);
    mr(4'h2);
    mw(4'h8, 8'h00);
    chk1(sys_rst, 1'b0);
    mw(4'h3, 8'h10);
    mw(4'h8, 8'h59);
    chk1(reset_nack, 1'b0);
    mw(4'h8, 8'h12);
    chk1(sys_rst, 1'b1);
    mw(4'h8, 8'h00);
    ls_busy = 1'b0;
    mw(4'h7, 8'h20);
    chk1(session_end, 1'b1);
    mr(4'h7);
    // Disable clears configuration and keys, enable restores the divider
    mw(4'h9, 8'h01);
    kp(3'h2);
    err(1);
    mw(4'h3, 8'h04);
    chk1(enabled, 1'b0);
    chk1(clk_req, 1'b0);
    dbg.wr(4'h2, 8'hFF);
    @(negedge sys_clk) en_p = 1'b1;
    @(negedge sys_clk) en_p = 1'b0;
    chk1(enabled, 1'b1);
    check({6'h00, div}, 8'h03);
    for (int a = 1; a < 10; a++) mr(a[3:0]);
    end_of_test();
  end
endmodule : debug_port_control_regs_tb
